// ### pkg/bpg_pkg.sv
// constants and carrier types for the three-port bidirectional gpio group
package bpg_pkg;
	localparam logic [7:0] OFS_C_PINS  = 8'h00;
	localparam logic [7:0] OFS_C_LATCH = 8'h04;
	localparam logic [7:0] OFS_C_DIR   = 8'h08;
	localparam logic [7:0] OFS_D_PINS  = 8'h0c;
	localparam logic [7:0] OFS_D_LATCH = 8'h10;
	localparam logic [7:0] OFS_D_DIR   = 8'h14;
	localparam logic [7:0] OFS_E_PINS  = 8'h18;
	localparam logic [7:0] OFS_E_LATCH = 8'h1c;
	localparam logic [7:0] OFS_E_DIR   = 8'h20;
	localparam logic [7:0] OFS_PSP_CTL = 8'h24;

	localparam logic [7:0] DIR_RESET  = 8'hff;
	localparam logic [7:0] ALL_DRIVE  = 8'hff;
	localparam logic [7:0] NONE_DRIVE = 8'h00;
	localparam logic [3:0] CTL_LOW_RD = 4'h0;

	localparam int CTL_INPUT_OVERFLOW_BIT = 5;
	localparam int CTL_MODE_BIT = 4;
	localparam int STB_RD_BIT   = 0;
	localparam int STB_WR_BIT   = 1;
	localparam int STB_CS_BIT   = 2;
	localparam int SHARED_BIT   = 7;

	localparam int PORT_C = 0;
	localparam int PORT_D = 1;
	localparam int PORT_E = 2;

	typedef enum logic [1:0]
	{
		KIND_PINS  = 2'h0,
		KIND_LATCH = 2'h1,
		KIND_DIR   = 2'h2
	} bpg_kind_t;

	typedef struct packed
	{
		logic [7:0] out;
		logic [7:0] oe;
	} bpg_pad_t;

	typedef struct packed
	{
		logic input_buffer_full;
		logic output_buffer_full;
		logic input_overflow;
		logic parallel_slave_enable;
	} bpg_psp_flags_t;
endpackage

// ### logic/bpg_ports.sv
// three 8-bit gpio ports with parallel slave mode, wishbone register access
// Operation
// R1: direction one on second port: input, hi-z
// R2: direction zero on second port: drive latch
// R3: third port direction behaves identically per bit
// R4: second port latch reads return latch
// R5: third port latch reads/writes latch only
// R6: pin register reads pins, writes latch
// R7: slave enable makes second port data bus
// R8: second port pin n is bus bit n
// R9: third port bit 0 is read strobe
// R10: third port bit 1 is write strobe
// R11: third port bit 2 is chip select
// R12: third port bit 7 shared with capture unit
// R13: pin and latch registers not reset
// R14: direction registers reset to all ones
// R15: control low nibble reads zero, upper resets
// R16: first port direction works the same way
// R17: peripheral direction override never stored
// R18: strobe pins forced input in slave mode
`timescale 1ns/1ps
module bpg_ports
	import bpg_pkg::*;
(
	input  wire logic               SYS_CLK,
	input  wire logic               RST,
	input  wire logic               WB_CYC_I,
	input  wire logic               WB_STB_I,
	input  wire logic               WB_WE_I,
	input  wire logic [3:0]         WB_SEL_I,
	input  wire logic [7:0]         WB_ADR_I,
	input  wire logic [31:0]        WB_DAT_I,
	output      logic [31:0]        WB_DAT_O,
	output      logic               WB_ACK_O,
	input  wire logic [7:0]         PORT_C_IN,
	output      bpg_pkg::bpg_pad_t  PORT_C_PAD,
	input  wire logic [7:0]         PORT_D_IN,
	output      bpg_pkg::bpg_pad_t  PORT_D_PAD,
	input  wire logic [7:0]         PORT_E_IN,
	output      bpg_pkg::bpg_pad_t  PORT_E_PAD,
	input  wire logic               CAPTURE_COMPARE_TWO_USE,
	input  wire logic               CAPTURE_COMPARE_TWO_DRIVE,
	input  wire logic               CAPTURE_COMPARE_TWO_OUT,
	output      logic               CAPTURE_COMPARE_TWO_CAPTURE
);
	import bpg_pkg::*;

	logic [7:0]      dir  [3];
	logic [7:0]      lat  [3];
	logic [7:0]      pins [3];
	logic [7:0]      pin_in [3];
	logic            req;
	logic            wr_go;
	logic            rd_go;
	logic [7:0]      rdata;
	logic [7:0]      psp_in;
	bpg_psp_flags_t  flags;
	logic            parallel_slave_enable;
	logic            input_buffer_full;
	logic            output_buffer_full;
	logic            input_overflow;
	logic            c_lat_written;
	logic            host_rd;
	logic            host_wr;
	logic            host_rd_q;
	logic            host_wr_q;
	logic            host_wr_end;
	logic            host_rd_end;
	logic            wr_d_data;
	logic            rd_d_pins;
	bpg_pad_t        next_c;
	bpg_pad_t        next_d;
	bpg_pad_t        next_e;

	function automatic logic [7:0] reg_ofs(input int port, input bpg_kind_t kind);
		logic [7:0] base;
		base = OFS_E_PINS;
		if (port == PORT_C)
			base = OFS_C_PINS;
		else if (port == PORT_D)
			base = OFS_D_PINS;
		unique case (kind)
			KIND_PINS:  reg_ofs = base;
			KIND_LATCH: reg_ofs = 8'(base + (OFS_C_LATCH - OFS_C_PINS));
			default:    reg_ofs = 8'(base + (OFS_C_DIR - OFS_C_PINS));
		endcase
	endfunction

	function automatic logic hits(input logic [7:0] adr, input int port, input bpg_kind_t kind);
		hits = (adr == reg_ofs(port, kind));
	endfunction

	assign pin_in[PORT_C] = PORT_C_IN;
	assign pin_in[PORT_D] = PORT_D_IN;
	assign pin_in[PORT_E] = PORT_E_IN;

	// a transfer takes effect on the edge where ack is seen high
	assign req   = WB_CYC_I & WB_STB_I;
	assign wr_go = req & WB_ACK_O & WB_WE_I & WB_SEL_I[0];
	assign rd_go = req & WB_ACK_O & ~WB_WE_I;

	always_ff @(posedge SYS_CLK)
	begin
		if (RST)
			WB_ACK_O <= 1'b0;
		else
			WB_ACK_O <= req & ~WB_ACK_O;
	end

	genvar p;
	generate
		for (p = 0; p < 3; p++)
		begin : g_port
			// direction keeps only what software wrote; overrides act on the pad
			always_ff @(posedge SYS_CLK)
			begin
				if (RST)
					dir[p] <= DIR_RESET;  // see R14
				else if (wr_go && hits(WB_ADR_I, p, KIND_DIR))
					dir[p] <= WB_DAT_I[7:0];  // see R17
			end

			// latch and pin sample carry no reset so they survive warm resets
			always_ff @(posedge SYS_CLK)
			begin
				if (wr_go && (hits(WB_ADR_I, p, KIND_LATCH) || hits(WB_ADR_I, p, KIND_PINS)))
					lat[p] <= WB_DAT_I[7:0];  // see R5 R6 R13
			end

			always_ff @(posedge SYS_CLK)
			begin
				pins[p] <= pin_in[p];  // see R13
			end
		end
	endgenerate

	// the c latch powers up unknown, so its pad check waits for a first write
	always_ff @(posedge SYS_CLK)
	begin
		if (RST)
			c_lat_written <= 1'b0;
		else if (wr_go && (hits(WB_ADR_I, PORT_C, KIND_LATCH)
			|| hits(WB_ADR_I, PORT_C, KIND_PINS)))
			c_lat_written <= 1'b1;
	end

	// parallel slave strobes are active low, inputs taken as synchronous
	assign host_rd = flags.parallel_slave_enable & ~PORT_E_IN[STB_RD_BIT]
		& ~PORT_E_IN[STB_CS_BIT];  // see R9 R11
	assign host_wr = flags.parallel_slave_enable & ~PORT_E_IN[STB_WR_BIT]
		& ~PORT_E_IN[STB_CS_BIT];  // see R10 R11
	assign host_wr_end = host_wr_q & ~host_wr;
	assign host_rd_end = host_rd_q & ~host_rd;
	assign wr_d_data = wr_go & (hits(WB_ADR_I, PORT_D, KIND_LATCH)
		| hits(WB_ADR_I, PORT_D, KIND_PINS));
	assign rd_d_pins = rd_go & hits(WB_ADR_I, PORT_D, KIND_PINS);

	// one driver for the flag word; every field keeps its own process
	assign flags = {input_buffer_full, output_buffer_full, input_overflow, parallel_slave_enable};

	always_ff @(posedge SYS_CLK)
	begin
		if (RST)
		begin
			host_rd_q <= 1'b0;
			host_wr_q <= 1'b0;
		end
		else
		begin
			host_rd_q <= host_rd;
			host_wr_q <= host_wr;
		end
	end

	// bus data is sampled every cycle in slave mode while write strobe and chip select are both low, and held once either returns high
	always_ff @(posedge SYS_CLK)
	begin
		if (host_wr)
			psp_in <= PORT_D_IN;  // see R8
	end

	always_ff @(posedge SYS_CLK)
	begin
		if (RST)
			parallel_slave_enable <= 1'b0;  // see R15
		else if (wr_go && WB_ADR_I == OFS_PSP_CTL)
			parallel_slave_enable <= WB_DAT_I[CTL_MODE_BIT];  // see R7
	end

	// a host write that ends in the same cycle as the clearing read wins
	always_ff @(posedge SYS_CLK)
	begin
		if (RST)
			input_buffer_full <= 1'b0;  // see R15
		else if (host_wr_end)
			input_buffer_full <= 1'b1;
		else if (rd_d_pins && flags.parallel_slave_enable)
			input_buffer_full <= 1'b0;
	end

	always_ff @(posedge SYS_CLK)
	begin
		if (RST)
			output_buffer_full <= 1'b0;  // see R15
		else if (wr_d_data && flags.parallel_slave_enable)
			output_buffer_full <= 1'b1;
		else if (host_rd_end)
			output_buffer_full <= 1'b0;
	end

	// overflow is sticky until software writes it back to zero
	always_ff @(posedge SYS_CLK)
	begin
		if (RST)
			input_overflow <= 1'b0;  // see R15
		else if (host_wr_end && flags.input_buffer_full)
			input_overflow <= 1'b1;
		else if (wr_go && WB_ADR_I == OFS_PSP_CTL && !WB_DAT_I[CTL_INPUT_OVERFLOW_BIT])
			input_overflow <= 1'b0;
	end

	always_comb
	begin
		next_c.oe  = ~dir[PORT_C];  // see R1 R2 R16
		next_c.out = lat[PORT_C];   // see R2
	end

	always_comb
	begin
		next_d.out = lat[PORT_D];
		if (flags.parallel_slave_enable)
			next_d.oe = host_rd ? ALL_DRIVE : NONE_DRIVE;  // see R7 R8
		else
			next_d.oe = ~dir[PORT_D];  // see R1 R2
	end

	// overrides shape the pad only, never the stored direction
	always_comb
	begin
		next_e.oe  = ~dir[PORT_E];  // see R3
		next_e.out = lat[PORT_E];
		if (flags.parallel_slave_enable)
		begin
			next_e.oe[STB_RD_BIT] = 1'b0;  // see R18
			next_e.oe[STB_WR_BIT] = 1'b0;  // see R18
			next_e.oe[STB_CS_BIT] = 1'b0;  // see R18
		end
		if (CAPTURE_COMPARE_TWO_USE)
		begin
			next_e.oe[SHARED_BIT]  = CAPTURE_COMPARE_TWO_DRIVE;  // see R12 R17
			next_e.out[SHARED_BIT] = CAPTURE_COMPARE_TWO_OUT;    // see R12
		end
	end

	// pads lag their cause by one cycle since every output is registered
	always_ff @(posedge SYS_CLK)
	begin
		if (RST)
		begin
			PORT_C_PAD <= '0;
			PORT_D_PAD <= '0;
			PORT_E_PAD <= '0;
		end
		else
		begin
			PORT_C_PAD <= next_c;
			PORT_D_PAD <= next_d;
			PORT_E_PAD <= next_e;
		end
	end

	always_ff @(posedge SYS_CLK)
	begin
		if (RST)
			CAPTURE_COMPARE_TWO_CAPTURE <= 1'b0;
		else
			CAPTURE_COMPARE_TWO_CAPTURE <= PORT_E_IN[SHARED_BIT];  // see R12
	end

	always_comb
	begin
		rdata = 8'h00;
		unique case (WB_ADR_I)
			OFS_C_PINS:  rdata = pins[PORT_C];  // see R6
			OFS_C_LATCH: rdata = lat[PORT_C];
			OFS_C_DIR:   rdata = dir[PORT_C];
			OFS_D_PINS:  rdata = flags.parallel_slave_enable ? psp_in : pins[PORT_D];
			OFS_D_LATCH: rdata = lat[PORT_D];   // see R4
			OFS_D_DIR:   rdata = dir[PORT_D];
			OFS_E_PINS:  rdata = pins[PORT_E];  // see R6
			OFS_E_LATCH: rdata = lat[PORT_E];   // see R5
			OFS_E_DIR:   rdata = dir[PORT_E];
			OFS_PSP_CTL: rdata = {flags, CTL_LOW_RD};  // see R15
			default:     rdata = 8'h00;
		endcase
	end

	// read data is captured with the rising ack; unmapped reads return zero
	always_ff @(posedge SYS_CLK)
	begin
		if (RST)
			WB_DAT_O <= 32'h0;
		else if (req && !WB_ACK_O)
			WB_DAT_O <= {24'h0, rdata};
	end

	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (RST);

	a_dir_reset_ones: // see R14
	assert property ($fell(RST) |-> dir[PORT_C] == DIR_RESET && dir[PORT_D] == DIR_RESET
		&& dir[PORT_E] == DIR_RESET)
		else $error("direction not all ones after reset");

	a_c_pad_drive: // see R1 R2 R16
	assert property (##1 PORT_C_PAD.oe == ~$past(dir[PORT_C]))
		else $error("port c pad enable does not follow direction");

	a_c_pad_out: // see R2 R16
	assert property (c_lat_written |=> PORT_C_PAD.out == $past(lat[PORT_C]))
		else $error("port c pad does not drive the latch");

	a_d_pad_io: // see R1 R2
	assert property (!flags.parallel_slave_enable |=> PORT_D_PAD.oe == ~$past(dir[PORT_D]))
		else $error("port d pad enable wrong in io mode");

	a_e_pad_io: // see R3
	assert property (!flags.parallel_slave_enable && !CAPTURE_COMPARE_TWO_USE
		|=> PORT_E_PAD.oe == ~$past(dir[PORT_E]))
		else $error("port e pad enable wrong");

	a_latch_readback: // see R4
	assert property (rd_go && WB_ADR_I == OFS_D_LATCH |-> WB_DAT_O[7:0] == lat[PORT_D])
		else $error("latch read does not return latch");

	a_pins_readback: // see R6
	assert property (##2 rd_go && WB_ADR_I == OFS_E_PINS
		|-> WB_DAT_O[7:0] == $past(PORT_E_IN, 2))
		else $error("pin read does not return pin level");

	a_psp_drive_bus: // see R7 R8
	assert property (host_rd |=> PORT_D_PAD.oe == ALL_DRIVE
		&& PORT_D_PAD.out == $past(lat[PORT_D]))
		else $error("slave read does not drive data bus");

	a_strobes_input: // see R18
	assert property (flags.parallel_slave_enable |=> PORT_E_PAD.oe[2:0] == 3'h0)
		else $error("strobe pins driven in slave mode");

	a_ctl_low_zero: // see R15
	assert property (rd_go && WB_ADR_I == OFS_PSP_CTL |-> WB_DAT_O[3:0] == CTL_LOW_RD)
		else $error("control low nibble not zero");

	a_dir_no_force: // see R17
	assert property (!(wr_go && WB_ADR_I == OFS_E_DIR) |=> $stable(dir[PORT_E]))
		else $error("direction changed without a write");

	a_shared_pin: // see R12
	assert property (CAPTURE_COMPARE_TWO_USE && CAPTURE_COMPARE_TWO_DRIVE |=> PORT_E_PAD.oe[SHARED_BIT]
		&& PORT_E_PAD.out[SHARED_BIT] == $past(CAPTURE_COMPARE_TWO_OUT))
		else $error("capture unit output not on shared pin");

	a_host_write_full: // see R10
	assert property (host_wr_end |=> flags.input_buffer_full)
		else $error("input buffer full not set by host write");

	a_host_overflow: // see R10
	assert property (host_wr_end && flags.input_buffer_full |=> flags.input_overflow)
		else $error("second host write did not flag overflow");

	a_bus_capture: // see R8
	assert property (host_wr |=> psp_in == $past(PORT_D_IN))
		else $error("host write data not captured bit for bit");

	a_capture_copy: // see R12
	assert property (!RST |=> CAPTURE_COMPARE_TWO_CAPTURE == $past(PORT_E_IN[SHARED_BIT]))
		else $error("capture input not copied from shared pin");

	a_ack_one_cycle:
	assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("ack held longer than one cycle");
endmodule

// ### sim/bpg_pin_model.sv
// far-side pin model: each pin resolved from block drive and outside drive
`timescale 1ns/1ps
module bpg_pin_model
	import bpg_pkg::*;
(
	input  wire logic              clk,
	input  wire bpg_pkg::bpg_pad_t pad,
	input  wire logic [7:0]        ext_val,
	input  wire logic [7:0]        ext_en,
	output      logic [7:0]        pin
);
	logic [7:0] float_pat = 8'h5a;
	// undriven pins toggle each cycle so a stale level never reads as a match
	always_ff @(posedge clk)
		float_pat <= ~float_pat;
	always_comb
		for (int i = 0; i < 8; i++)
			pin[i] = pad.oe[i] ? pad.out[i] : ext_en[i] ? ext_val[i] : float_pat[i];
endmodule

// ### sim/bidir_port_group_cde_tb.sv
// self-checking bench for the three-port gpio group
`timescale 1ns/1ps
`define CHK(nm, e, a) begin total_checks++; if ((a) !== (e)) begin n_fail++; \
	$display("ERROR %s expected %h seen %h", nm, e, a); end end
module bidir_port_group_cde_tb;
	import bpg_pkg::*;
	logic              SYS_CLK = 0;
	logic              RST = 1;
	logic              cyc = 0, stb = 0, we = 0, cap;
	logic [3:0]        sel = 4'h1;
	logic [7:0]        adr = 0, wd = 0, rd;
	logic [31:0]       dat_o;
	logic              ack, ccp_use = 0, ccp_drv = 0, ccp_out = 0;
	logic [7:0]        c_ev = 8'h3c, c_en = 8'h0f, d_ev = 0, d_en = 0, e_ev = 0, e_en = 0;
	logic [7:0]        c_pin, d_pin, e_pin;
	bpg_pad_t          c_pad, d_pad, e_pad;
	int                n_fail = 0, total_checks = 0;

	always #12.5 SYS_CLK = ~SYS_CLK;

	bpg_ports uut (.SYS_CLK(SYS_CLK), .RST(RST), .WB_CYC_I(cyc), .WB_STB_I(stb),
		.WB_WE_I(we), .WB_SEL_I(sel), .WB_ADR_I(adr), .WB_DAT_I({24'h0, wd}),
		.WB_DAT_O(dat_o), .WB_ACK_O(ack), .PORT_C_IN(c_pin), .PORT_C_PAD(c_pad),
		.PORT_D_IN(d_pin), .PORT_D_PAD(d_pad), .PORT_E_IN(e_pin), .PORT_E_PAD(e_pad),
		.CAPTURE_COMPARE_TWO_USE(ccp_use), .CAPTURE_COMPARE_TWO_DRIVE(ccp_drv), .CAPTURE_COMPARE_TWO_OUT(ccp_out), .CAPTURE_COMPARE_TWO_CAPTURE(cap));
	bpg_pin_model pc (.clk(SYS_CLK), .pad(c_pad), .ext_val(c_ev), .ext_en(c_en), .pin(c_pin));
	bpg_pin_model pd (.clk(SYS_CLK), .pad(d_pad), .ext_val(d_ev), .ext_en(d_en), .pin(d_pin));
	bpg_pin_model pe (.clk(SYS_CLK), .pad(e_pad), .ext_val(e_ev), .ext_en(e_en), .pin(e_pin));

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// classic single cycle; request held until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
		input logic [3:0] s = 4'h1);
		int n;
		n = 0;
		@(posedge SYS_CLK);
		cyc <= 1;
		stb <= 1;
		we <= w;
		sel <= s;
		adr <= a;
		wd <= d;
		do
		begin
			@(posedge SYS_CLK);
			n++;
		end
		while (ack !== 1'b1 && n < 20);
		if (ack !== 1'b1)
		begin
			n_fail++;
			print_verdict();
		end
		else
		begin
			rd = dat_o[7:0];
			cyc <= 0;
			stb <= 0;
			we <= 0;
			@(posedge SYS_CLK);
		end
	endtask

	task automatic chk(input logic [7:0] a, input logic [7:0] e, input string nm);
		wb(0, a, 8'h00);
		`CHK(nm, e, rd)
	endtask

	task automatic settle();
		repeat (3) @(posedge SYS_CLK);
		#1;
	endtask

	// host strobes on e[2:0] are active low: rd, wr, cs
	task automatic host(input logic [2:0] s);
		@(posedge SYS_CLK);
		e_ev[2:0] <= s;
		@(posedge SYS_CLK);
		e_ev[2:0] <= 3'b111;
		settle();
	endtask

	initial
	begin
		repeat (12) @(posedge SYS_CLK);
		RST <= 0;
		#1;
		`CHK("c_oe", 8'h00, c_pad.oe)
		chk(OFS_C_DIR, 8'hff, "c_dir");
		chk(OFS_D_DIR, 8'hff, "d_dir");
		chk(OFS_E_DIR, 8'hff, "e_dir");
		chk(OFS_PSP_CTL, 8'h00, "ctl");
		wb(1, OFS_C_LATCH, 8'ha5);
		wb(1, OFS_C_DIR, 8'h0f);
		settle();
		`CHK("c_oe", 8'hf0, c_pad.oe)
		chk(OFS_C_PINS, 8'hac, "c_pins");
		wb(1, OFS_C_LATCH, 8'hff, 4'h0);
		chk(OFS_C_LATCH, 8'ha5, "c_latch");
		wb(1, OFS_D_PINS, 8'h5a);
		chk(OFS_D_LATCH, 8'h5a, "d_latch");
		wb(1, OFS_D_DIR, 8'h00);
		settle();
		chk(OFS_D_PINS, 8'h5a, "d_pins");
		wb(1, OFS_E_LATCH, 8'hc3);
		chk(OFS_E_LATCH, 8'hc3, "e_latch");
		wb(1, OFS_E_DIR, 8'h00);
		settle();
		chk(OFS_E_PINS, 8'hc3, "e_pins");
		// warm reset in mid-run: latches survive, directions return to inputs
		RST <= 1;
		repeat (2) @(posedge SYS_CLK);
		RST <= 0;
		chk(OFS_C_LATCH, 8'ha5, "c_latch_kept");
		chk(OFS_E_LATCH, 8'hc3, "e_latch_kept");
		chk(OFS_D_DIR, 8'hff, "d_dir_rst");
		`CHK("e_oe_rst", 8'h00, e_pad.oe)
		wb(1, OFS_E_DIR, 8'h00);
		chk(8'h28, 8'h00, "unmapped");
		wb(1, OFS_PSP_CTL, 8'h0f);
		chk(OFS_PSP_CTL, 8'h00, "ctl_low");
		d_ev <= 8'h96;
		d_en <= 8'hff;
		e_ev <= 8'h07;
		e_en <= 8'h07;
		wb(1, OFS_PSP_CTL, 8'h10);
		settle();
		`CHK("e_oe", 8'hf8, e_pad.oe)
		`CHK("d_oe", 8'h00, d_pad.oe)
		host(3'b101);
		chk(OFS_PSP_CTL, 8'h10, "no_cs");
		host(3'b001);
		chk(OFS_PSP_CTL, 8'h90, "ibf");
		host(3'b001);
		chk(OFS_PSP_CTL, 8'hb0, "input_overflow");
		chk(OFS_D_PINS, 8'h96, "d_bus");
		chk(OFS_PSP_CTL, 8'h30, "ibf_clr");
		wb(1, OFS_PSP_CTL, 8'h10);
		d_en <= 8'h00;
		wb(1, OFS_D_LATCH, 8'h3c);
		chk(OFS_PSP_CTL, 8'h50, "obf");
		e_ev[2:0] <= 3'b010;
		settle();
		`CHK("d_oe_rd", 8'hff, d_pad.oe)
		`CHK("d_rd", 8'h3c, d_pin)
		@(posedge SYS_CLK);
		e_ev[2:0] <= 3'b111;
		settle();
		chk(OFS_PSP_CTL, 8'h10, "obf_clr");
		wb(1, OFS_PSP_CTL, 8'h00);
		ccp_use <= 1;
		ccp_drv <= 1;
		settle();
		`CHK("e7_cmp", 1'b0, e_pin[7])
		chk(OFS_E_DIR, 8'h00, "e_dir_kept");
		ccp_drv <= 0;
		e_ev[7] <= 1;
		e_en[7] <= 1;
		settle();
		`CHK("e7_oe", 1'b0, e_pad.oe[7])
		`CHK("e7_cap", 1'b1, cap)
		print_verdict();
	end
endmodule
